//--- logic/serdes_cfg_bus_if.sv
`timescale 1ns/1ps
interface serdes_cfg_bus_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic scl;
  logic sda;
  // wired-and with pull-up
  assign scl = hostSclOe ? hostSclOut : 1'b1;
  assign sda = (hostSdaOe ? hostSdaOut : 1'b1) & (devSdaOe ? devSdaOut : 1'b1);
  modport dev (input scl, input sda, output devSdaOut, output devSdaOe);
  modport host (input scl, input sda, output hostSclOut, output hostSclOe,
    output hostSdaOut, output hostSdaOe);
endinterface

//--- logic/serdes_cfg_device.sv
// The implementer's own choice: the serial bus interface to the registers, with scl and sda sampled on clk_sys.
`timescale 1ns/1ps
module serdes_cfg_device #(
  parameter bit isDeser = 1'b0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  serdes_cfg_bus_if.dev bus,
  input wire logic powerDownN,
  input wire logic [1:0] addressStrapInput,
  input wire logic [7:0] pinConfig,
  output logic captureEdgeSelect,
  output logic outputSwingSelect,
  output logic filterEnable,
  output logic sleepMode,
  output logic lowBandSpread,
  output logic clockOutFastSlew,
  output logic registerOverride,
  output logic [2:0] emphasisLevel,
  output logic emphasisOff,
  output serdes_cfg_pkg::addr_t activeAddress
);
  import serdes_cfg_pkg::*;

  localparam logic [7:0] CFG_MASK = isDeser ? DES_CFG_MASK : SER_CFG_MASK;
  localparam logic [7:0] ADDR_RST = isDeser ? DES_ADDR_RST : SER_ADDR_RST;

  typedef struct packed {
    dev_state_t st;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic rw;
    logic first;
    logic more;
    logic sdaLow;
    logic [7:0] index;
    logic [7:0] cfgReg;
    logic [7:0] addrReg;
    logic [7:0] emphReg;
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [1:0] pdSync;
    logic sclPrev;
    logic sdaPrev;
    logic [7:0] pinSync1;
    logic [7:0] pinSync2;
    logic [1:0] strapSync1;
    logic [1:0] strapSync2;
    logic capEdge;
    logic swing;
    logic filt;
    logic sleep;
    logic band;
    logic slew;
    logic ovr;
    logic [2:0] emphLvl;
    logic emphOff;
    addr_t actAddr;
  } dev_t;

  localparam dev_t DEV_RST = '{st: D_IDLE, cfgReg: CONFIG_ONE_RST, addrReg: ADDR_RST,
    emphReg: DEEMPH_RST, sclSync: 2'h3, sdaSync: 2'h3, sclPrev: 1'b1, sdaPrev: 1'b1,
    emphLvl: EMPH_BY_RESISTOR, default: '0};

  dev_t r;
  dev_t n;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [7:0] eff;
  logic [7:0] rdData;
  addr_t strapAddr;

  function automatic logic [7:0] rdReg(input logic [7:0] idx, input dev_t s);
    case (idx)
      REG_CONFIG_ONE: rdReg = s.cfgReg;
      REG_SLAVE_ADDR: rdReg = s.addrReg;
      REG_DEEMPH: rdReg = s.emphReg;
      default: rdReg = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.sclSync = {r.sclSync[0], bus.scl};
    n.sdaSync = {r.sdaSync[0], bus.sda};
    n.pdSync = {r.pdSync[0], powerDownN};
    n.pinSync1 = pinConfig;
    n.pinSync2 = r.pinSync1;
    n.strapSync1 = addressStrapInput;
    n.strapSync2 = r.strapSync1;
    sclS = r.sclSync[1];
    sdaS = r.sdaSync[1];
    n.sclPrev = sclS;
    n.sdaPrev = sdaS;
    sclRise = sclS & ~r.sclPrev;
    sclFall = ~sclS & r.sclPrev;
    startSeen = sclS & r.sclPrev & r.sdaPrev & ~sdaS;
    stopSeen = sclS & r.sclPrev & ~r.sdaPrev & sdaS;
    rdData = rdReg(r.index, r);

    // effective configuration
    n.ovr = r.cfgReg[OVERRIDE_BIT];
    eff = r.cfgReg[OVERRIDE_BIT] ? r.cfgReg : (r.pinSync2 & CFG_MASK);
    n.capEdge = eff[EDGE_BIT];
    n.swing = eff[SWING_BIT];
    n.filt = (eff[FILTER_LSB +: 2] == FILTER_ON);
    n.sleep = eff[SLEEP_BIT];
    n.band = isDeser & eff[BAND_BIT];
    n.slew = isDeser & eff[SLEW_BIT];
    n.emphLvl = r.cfgReg[OVERRIDE_BIT] ? r.emphReg[EMPH_LSB +: 3] : EMPH_BY_RESISTOR;
    n.emphOff = r.cfgReg[OVERRIDE_BIT] & r.emphReg[EMPH_OFF_BIT];
    strapAddr = isDeser ? DES_ADDR_TABLE[r.strapSync2] : SER_ADDR_TABLE[r.strapSync2];
    n.actAddr = r.addrReg[ADDR_SRC_BIT] ? r.addrReg[6:0] : strapAddr;

    // serial protocol engine
    if (startSeen) begin
      n.st = D_ADDR;
      n.bitCnt = 4'h0;
      n.sdaLow = 1'b0;
    end else if (stopSeen) begin
      n.st = D_IDLE;
      n.sdaLow = 1'b0;
    end else begin
      case (r.st)
        D_ADDR: begin
          if (sclRise && r.bitCnt != 4'h8) begin
            n.shift = {r.shift[6:0], sdaS};
            n.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == 4'h8) begin
            if (r.shift[7:1] == r.actAddr) begin
              n.st = D_AACK;
              n.sdaLow = 1'b1;
              n.rw = r.shift[0];
            end else begin
              n.st = D_IDLE;
            end
          end
        end
        D_AACK: begin
          if (sclFall) begin
            if (r.rw) begin
              n.st = D_RBYTE;
              n.sdaLow = ~rdData[7];
              n.shift = {rdData[6:0], 1'b0};
              n.bitCnt = 4'h1;
              n.more = 1'b0;
            end else begin
              n.st = D_WBYTE;
              n.sdaLow = 1'b0;
              n.bitCnt = 4'h0;
              n.first = 1'b1;
            end
          end
        end
        D_WBYTE: begin
          if (sclRise && r.bitCnt != 4'h8) begin
            n.shift = {r.shift[6:0], sdaS};
            n.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == 4'h8) begin
            n.st = D_WACK;
            n.sdaLow = 1'b1;
            n.first = 1'b0;
            if (r.first) begin
              n.index = r.shift;
            end else begin
              n.index = r.index + 8'h01;
              case (r.index)
                REG_CONFIG_ONE: n.cfgReg = r.shift & CFG_MASK;
                REG_SLAVE_ADDR: n.addrReg = r.shift;
                REG_DEEMPH: n.emphReg = r.shift & DEEMPH_MASK;
                default: n.cfgReg = r.cfgReg;
              endcase
            end
          end
        end
        D_WACK: begin
          if (sclFall) begin
            n.st = D_WBYTE;
            n.sdaLow = 1'b0;
            n.bitCnt = 4'h0;
          end
        end
        D_RBYTE: begin
          if (sclFall) begin
            if (r.bitCnt == 4'h8) begin
              n.st = D_RACK;
              n.sdaLow = 1'b0;
            end else begin
              n.sdaLow = ~r.shift[7];
              n.shift = {r.shift[6:0], 1'b0};
              n.bitCnt = r.bitCnt + 4'h1;
            end
          end
        end
        D_RACK: begin
          if (sclRise) begin
            if (!sdaS) begin
              n.more = 1'b1;
              n.index = r.index + 8'h01;
            end else begin
              n.st = D_IDLE;
            end
          end else if (sclFall && r.more) begin
            n.st = D_RBYTE;
            n.sdaLow = ~rdData[7];
            n.shift = {rdData[6:0], 1'b0};
            n.bitCnt = 4'h1;
            n.more = 1'b0;
          end
        end
        default: n.sdaLow = 1'b0;
      endcase
    end

    if (!r.pdSync[1]) begin
      n.st = D_IDLE;
      n.sdaLow = 1'b0;
      n.index = 8'h00;
      n.cfgReg = CONFIG_ONE_RST;
      n.addrReg = ADDR_RST;
      n.emphReg = DEEMPH_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign bus.devSdaOut = 1'b0;
  assign bus.devSdaOe = r.sdaLow;
  assign captureEdgeSelect = r.capEdge;
  assign outputSwingSelect = r.swing;
  assign filterEnable = r.filt;
  assign sleepMode = r.sleep;
  assign lowBandSpread = r.band;
  assign clockOutFastSlew = r.slew;
  assign registerOverride = r.ovr;
  assign emphasisLevel = r.emphLvl;
  assign emphasisOff = r.emphOff;
  assign activeAddress = r.actAddr;
endmodule // serdes_cfg_device

//--- logic/serdes_cfg_host.sv
`timescale 1ns/1ps
module serdes_cfg_host (
  input wire logic clk_sys,
  input wire logic sys_rst,
  serdes_cfg_bus_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output serdes_cfg_pkg::host_state_t hostState
);
  import serdes_cfg_pkg::*;

  localparam logic [7:0] QUARTER_CNT = 8'(QUARTER_CYC - 1);

  typedef struct packed {
    host_state_t st;
    logic [2:0] opIdx;
    logic [3:0] bitIdx;
    logic [1:0] q;
    logic [7:0] cnt;
    logic sclOe;
    logic sdaOe;
    logic [1:0] sdaSync;
    logic rd;
    addr_t addr;
    logic [7:0] index;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic busy;
    logic nack;
    logic [31:0] prd;
  } host_t;

  host_t r;
  host_t n;
  op_t kind;
  logic [7:0] txByte;
  logic [3:0] bitPos;
  logic last;
  logic isW;
  logic sdaS;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.sdaSync = {r.sdaSync[0], bus.sda};
    sdaS = r.sdaSync[1];
    mapped = (paddr == CMD_OFS) || (paddr == STATUS_OFS);

    // transaction sequence
    case (r.opIdx)
      3'h0: kind = OP_START;
      3'h1: kind = OP_WBYTE;
      3'h2: kind = OP_WBYTE;
      3'h3: kind = r.rd ? OP_START : OP_WBYTE;
      3'h4: kind = r.rd ? OP_WBYTE : OP_STOP;
      3'h5: kind = OP_RBYTE;
      default: kind = OP_STOP;
    endcase
    case (r.opIdx)
      3'h1: txByte = {r.addr, 1'b0};
      3'h2: txByte = r.index;
      3'h3: txByte = r.wdata;
      default: txByte = {r.addr, 1'b1};
    endcase
    bitPos = 4'h7 - r.bitIdx;
    last = (r.bitIdx == 4'h8);
    isW = (kind == OP_WBYTE);

    // apb slave
    if (psel && !penable) begin
      case (paddr)
        CMD_OFS: n.prd = {8'h00, r.wdata, r.index, r.rd, r.addr};
        STATUS_OFS: n.prd = {16'h0000, r.rdata, 6'h00, r.nack, r.busy};
        default: n.prd = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite && paddr == CMD_OFS && pwdata[CMD_GO_BIT] && !r.busy) begin
      n.st = H_RUN;
      n.busy = 1'b1;
      n.nack = 1'b0;
      n.addr = pwdata[6:0];
      n.rd = pwdata[CMD_RD_BIT];
      n.index = pwdata[CMD_IDX_LSB +: 8];
      n.wdata = pwdata[CMD_DATA_LSB +: 8];
      n.opIdx = 3'h0;
      n.bitIdx = 4'h0;
      n.q = 2'h0;
      n.cnt = QUARTER_CNT;
    end

    // bit engine, four quarters per bit
    if (r.st == H_RUN) begin
      if (r.cnt != 8'h00) begin
        n.cnt = r.cnt - 8'h01;
      end else begin
        n.cnt = QUARTER_CNT;
        n.q = r.q + 2'h1;
        case (kind)
          OP_START: begin
            case (r.q)
              2'h0: n.sdaOe = 1'b0;
              2'h1: n.sclOe = 1'b0;
              2'h2: n.sdaOe = 1'b1;
              default: begin
                n.sclOe = 1'b1;
                n.opIdx = r.opIdx + 3'h1;
              end
            endcase
          end
          OP_STOP: begin
            case (r.q)
              2'h0: n.sdaOe = 1'b1;
              2'h1: n.sclOe = 1'b0;
              2'h2: n.sdaOe = 1'b0;
              default: begin
                n.st = H_IDLE;
                n.busy = 1'b0;
              end
            endcase
          end
          default: begin
            case (r.q)
              2'h0: n.sdaOe = isW & ~last & ~txByte[bitPos[2:0]];
              2'h1: n.sclOe = 1'b0;
              2'h2: begin
                if (!last && !isW) begin
                  n.rdata = {r.rdata[6:0], sdaS};
                end
                if (last && isW && sdaS) begin
                  n.nack = 1'b1;
                end
              end
              default: begin
                n.sclOe = 1'b1;
                if (!last) begin
                  n.bitIdx = r.bitIdx + 4'h1;
                end else begin
                  n.bitIdx = 4'h0;
                  n.opIdx = r.nack ? (r.rd ? STOP_IDX_RD : STOP_IDX_WR) : r.opIdx + 3'h1;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= '{st: H_IDLE, sdaSync: 2'h3, default: '0};
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign bus.hostSclOut = 1'b0;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSclOe = r.sclOe;
  assign bus.hostSdaOe = r.sdaOe;
  assign prdata = r.prd;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign hostState = r.st;
endmodule // serdes_cfg_host

//--- logic/serdes_cfg_pkg.sv
package serdes_cfg_pkg;
  // device register map
  localparam logic [7:0] REG_CONFIG_ONE = 8'h00;
  localparam logic [7:0] REG_SLAVE_ADDR = 8'h01;
  localparam logic [7:0] REG_DEEMPH = 8'h02;
  localparam logic [7:0] CONFIG_ONE_RST = 8'h00;
  localparam logic [7:0] SER_ADDR_RST = 8'h68;
  localparam logic [7:0] DES_ADDR_RST = 8'h70;
  localparam logic [7:0] DEEMPH_RST = 8'h00;
  localparam logic [7:0] SER_CFG_MASK = 8'h3f;
  localparam logic [7:0] DES_CFG_MASK = 8'hff;
  localparam logic [7:0] DEEMPH_MASK = 8'hf0;
  // field positions
  localparam int OVERRIDE_BIT = 0;
  localparam int SLEEP_BIT = 1;
  localparam int FILTER_LSB = 2;
  localparam int SWING_BIT = 4;
  localparam int EDGE_BIT = 5;
  localparam int SLEW_BIT = 6;
  localparam int BAND_BIT = 7;
  localparam int ADDR_SRC_BIT = 7;
  localparam int EMPH_OFF_BIT = 4;
  localparam int EMPH_LSB = 5;
  localparam logic [1:0] FILTER_ON = 2'h1;
  localparam logic [2:0] EMPH_BY_RESISTOR = 3'h0;
  typedef logic [6:0] addr_t;
  // strap code 3 is the open pin
  localparam logic [3:0][6:0] SER_ADDR_TABLE = {7'h6e, 7'h6b, 7'h6a, 7'h69};
  localparam logic [3:0][6:0] DES_ADDR_TABLE = {7'h76, 7'h73, 7'h72, 7'h71};
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_ADDR = 3'h1,
    D_AACK = 3'h3,
    D_WBYTE = 3'h2,
    D_WACK = 3'h6,
    D_RBYTE = 3'h7,
    D_RACK = 3'h5
  } dev_state_t;
  // host controller apb map
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int CMD_RD_BIT = 7;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_DATA_LSB = 16;
  localparam int CMD_GO_BIT = 31;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [2:0] STOP_IDX_WR = 3'h4;
  localparam logic [2:0] STOP_IDX_RD = 3'h6;
  // bus clock timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_QUARTER_NS = 1250;
  localparam int QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic {H_IDLE = 1'b0, H_RUN = 1'b1} host_state_t;
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WBYTE = 2'h1,
    OP_RBYTE = 2'h3,
    OP_STOP = 2'h2
  } op_t;
endpackage

//--- tb/serdes_cfg_props.sv
`timescale 1ns/1ps
module serdes_cfg_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hostSclOut,
  input wire logic hostSclOe,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic scl,
  input wire logic sda
);
  import serdes_cfg_pkg::*;
  localparam int LOW_LIMIT = 2000;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // length of each device pull on sda
  logic [11:0] lowCnt_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !devSdaOe) begin
      lowCnt_r <= 12'h000;
    end else begin
      lowCnt_r <= lowCnt_r + 12'h001;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_host_scl_low: assert property (hostSclOe |-> hostSclOut == 1'b0)
    else $error("host drives scl high");
  a_host_sda_low: assert property (hostSdaOe |-> hostSdaOut == 1'b0)
    else $error("host drives sda high");
  a_dev_sda_low: assert property (devSdaOe |-> devSdaOut == 1'b0)
    else $error("device drives sda high");
  a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(devSdaOe))
    else $error("device moved sda while scl high");
  a_start_by_host: assert property ($fell(sda) && scl |-> hostSdaOe && !devSdaOe)
    else $error("start not made by host");
  a_stop_clean: assert property ($rose(sda) && scl |-> !devSdaOe && !hostSdaOe)
    else $error("stop seen with sda still pulled");
  a_ack_bounded: assert property (lowCnt_r < LOW_LIMIT)
    else $error("device pulls sda too long");
  a_pull_scl_low: assert property ($rose(devSdaOe) |-> !scl ##1 !scl)
    else $error("device pull began with scl high");
  a_release_scl_low: assert property ($fell(devSdaOe) |-> !scl)
    else $error("device release with scl high");
  c_dev_ack: cover property ($rose(devSdaOe));
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
endmodule // serdes_cfg_props

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import serdes_cfg_pkg::*;
  typedef struct {
    logic [6:0] wAdr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic wNack;
    logic [6:0] rAdr;
    logic [7:0] rExp;
  } row_t;
  logic clk_sys, sys_rst, psel, penable, pwrite, pslverr, pready, powerDownN, lastErr;
  logic [7:0] paddr, pinConfig;
  logic [31:0] pwdata, prdata, st;
  logic [1:0] addressStrapInput;
  logic captureEdgeSelect, outputSwingSelect, filterEnable, sleepMode;
  logic lowBandSpread, clockOutFastSlew, registerOverride, emphasisOff;
  logic [2:0] emphasisLevel;
  addr_t activeAddress;
  host_state_t hostState;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  row_t rows [4];
  logic [6:0] strapAddr [4];
  logic [7:0] desPinConfig;
  logic desBand, desSlew;
  addr_t desAddr;
  logic [6:0] desStrap [4];
  ////////////////////////////////////////////////////////////////
  serdes_cfg_bus_if serdes_cfg_bus_if_inst ();
  serdes_cfg_device #(.isDeser(1'b0)) serdes_cfg_device_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .bus(serdes_cfg_bus_if_inst), .powerDownN(powerDownN),
    .addressStrapInput(addressStrapInput), .pinConfig(pinConfig),
    .captureEdgeSelect(captureEdgeSelect), .outputSwingSelect(outputSwingSelect),
    .filterEnable(filterEnable), .sleepMode(sleepMode), .lowBandSpread(lowBandSpread),
    .clockOutFastSlew(clockOutFastSlew), .registerOverride(registerOverride),
    .emphasisLevel(emphasisLevel), .emphasisOff(emphasisOff),
    .activeAddress(activeAddress));
  serdes_cfg_host serdes_cfg_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus(serdes_cfg_bus_if_inst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hostState(hostState));
  serdes_cfg_props serdes_cfg_props_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .hostSclOut(serdes_cfg_bus_if_inst.hostSclOut),
    .hostSclOe(serdes_cfg_bus_if_inst.hostSclOe),
    .hostSdaOut(serdes_cfg_bus_if_inst.hostSdaOut),
    .hostSdaOe(serdes_cfg_bus_if_inst.hostSdaOe),
    .devSdaOut(serdes_cfg_bus_if_inst.devSdaOut),
    .devSdaOe(serdes_cfg_bus_if_inst.devSdaOe),
    .scl(serdes_cfg_bus_if_inst.scl), .sda(serdes_cfg_bus_if_inst.sda));
  // deserializer end, its bus held idle
  serdes_cfg_bus_if serdes_cfg_bus_if_des_inst ();
  assign serdes_cfg_bus_if_des_inst.hostSclOut = 1'b0;
  assign serdes_cfg_bus_if_des_inst.hostSclOe = 1'b0;
  assign serdes_cfg_bus_if_des_inst.hostSdaOut = 1'b0;
  assign serdes_cfg_bus_if_des_inst.hostSdaOe = 1'b0;
  serdes_cfg_device #(.isDeser(1'b1)) serdes_cfg_device_des_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .bus(serdes_cfg_bus_if_des_inst), .powerDownN(powerDownN),
    .addressStrapInput(addressStrapInput), .pinConfig(desPinConfig),
    .captureEdgeSelect(), .outputSwingSelect(), .filterEnable(), .sleepMode(),
    .lowBandSpread(desBand), .clockOutFastSlew(desSlew), .registerOverride(),
    .emphasisLevel(), .emphasisOff(), .activeAddress(desAddr));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one bus command, polled until idle
  task automatic bus_cmd(input logic rd, input logic [6:0] adr, input logic [7:0] idx,
    input logic [7:0] wd, output logic [31:0] s);
    apb(1'b1, CMD_OFS, {1'b1, 7'h00, wd, idx, rd, adr}, s);
    do begin
      apb(1'b0, STATUS_OFS, 32'h0, s);
    end while (s[STAT_BUSY_BIT] !== 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{7'h6e, 8'h00, 8'hff, 1'b0, 7'h6e, 8'h3f},
             '{7'h6e, 8'h02, 8'hff, 1'b0, 7'h6e, 8'hf0},
             '{7'h6e, 8'h01, 8'hd5, 1'b0, 7'h55, 8'hd5},
             '{7'h69, 8'h01, 8'h00, 1'b1, 7'h55, 8'hd5}};
    strapAddr = '{7'h69, 7'h6a, 7'h6b, 7'h6e};
    desStrap = '{7'h71, 7'h72, 7'h73, 7'h76};
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    powerDownN = 1'b1;
    pinConfig = 8'h20;
    desPinConfig = 8'hc0;
    addressStrapInput = 2'h3;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk_flag(registerOverride, 1'b0);
    chk_flag(captureEdgeSelect, 1'b1);
    chk_byte({1'b0, activeAddress}, 8'h6e);
    chk_flag(desBand, 1'b1);
    chk_flag(desSlew, 1'b1);
    chk_byte({1'b0, desAddr}, 8'h76);
    $display("test reset done");
    foreach (rows[i]) begin
      bus_cmd(1'b0, rows[i].wAdr, rows[i].idx, rows[i].wd, st);
      chk_flag(st[STAT_NACK_BIT], rows[i].wNack);
      bus_cmd(1'b1, rows[i].rAdr, rows[i].idx, 8'h00, st);
      chk_flag(st[STAT_NACK_BIT], 1'b0);
      chk_byte(st[15:8], rows[i].rExp);
      chk_flag(hostState, 1'b0);
      $display("test row %0d done", i);
    end
    chk_flag(registerOverride, 1'b1);
    chk_flag(captureEdgeSelect, 1'b1);
    chk_flag(outputSwingSelect, 1'b1);
    chk_flag(filterEnable, 1'b0);
    chk_flag(sleepMode, 1'b1);
    chk_byte({5'h00, emphasisLevel}, 8'h07);
    chk_flag(emphasisOff, 1'b1);
    chk_flag(lowBandSpread, 1'b0);
    chk_flag(clockOutFastSlew, 1'b0);
    chk_byte({1'b0, activeAddress}, 8'h55);
    bus_cmd(1'b0, 7'h55, 8'h00, 8'h05, st);
    chk_flag(filterEnable, 1'b1);
    chk_flag(captureEdgeSelect, 1'b0);
    chk_flag(sleepMode, 1'b0);
    $display("test override done");
    powerDownN <= 1'b0;
    desPinConfig <= 8'h40;
    repeat (5) @(posedge clk_sys);
    powerDownN <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk_flag(registerOverride, 1'b0);
    chk_flag(captureEdgeSelect, 1'b1);
    chk_flag(filterEnable, 1'b0);
    chk_byte({5'h00, emphasisLevel}, 8'h00);
    chk_flag(desBand, 1'b0);
    chk_flag(desSlew, 1'b1);
    for (int s = 3; s >= 0; s--) begin
      addressStrapInput <= s[1:0];
      repeat (8) @(posedge clk_sys);
      chk_byte({1'b0, activeAddress}, {1'b0, strapAddr[s]});
      chk_byte({1'b0, desAddr}, {1'b0, desStrap[s]});
    end
    bus_cmd(1'b1, 7'h69, 8'h01, 8'h00, st);
    chk_byte(st[15:8], 8'h68);
    $display("test power down done");
    apb(1'b0, 8'h08, 32'h0, st);
    chk_flag(lastErr, 1'b1);
    chk_byte(st[7:0], 8'h00);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule // tb_top
